// file: lss_pkg.sv
package lss_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint unsigned HOLDOFF_MS = 64'h0000_0000_0000_1388;
    localparam longint unsigned CLK_KHZ = 64'h0000_0000_0003_D090;
    // Exact product; 5000 ms at 250 MHz fits the 32-bit counter
    localparam longint unsigned HOLDOFF_CYC = HOLDOFF_MS * CLK_KHZ;
    localparam int unsigned CNT_W = 32;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_HOLD = 12'h008;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int unsigned CTRL_INH_BIT = 0;
    localparam int unsigned CTRL_SHUT_BIT = 1;
    localparam int unsigned STAT_LOOP_BIT = 0;
    localparam int unsigned STAT_READY_BIT = 1;
    localparam int unsigned STAT_DONE_BIT = 2;
    localparam int unsigned STAT_SHUT_BIT = 3;
    localparam int unsigned STAT_THERM_BIT = 4;
    localparam int unsigned STAT_EMISSION_INDICATOR_BIT = 5;
    localparam int unsigned STAT_FAULT_BIT = 6;
    localparam int unsigned STAT_RF_BIT = 7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic safety_loop;
        logic shutter_req;
        logic inhibit_req;
        logic over_temp;
        logic no_strike;
        logic pwm_cmd;
    } lss_in_t;

    typedef struct packed {
        logic rf_board_pwr;
        logic rf_driver_en;
        logic tickle_en;
        logic pulse_out;
        logic ready_closed;
        logic shutter_closed;
        logic loop_open_closed;
        logic fault_closed;
        logic lasing_closed;
        logic ready_indicator;
        logic shutter_indicator;
        logic loop_ind_green;
        logic thermal_indicator;
        logic emission_indicator;
    } lss_out_t;

endpackage

// file: lss_holdoff.sv
`timescale 1ns/10ps
`default_nettype none

module lss_holdoff
#(
    parameter longint unsigned CYCLES = lss_pkg::HOLDOFF_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic run,
    output logic done,
    output logic [lss_pkg::CNT_W-1:0] count
);

    localparam logic [lss_pkg::CNT_W-1:0] LAST = lss_pkg::CNT_W'(CYCLES);

    logic [lss_pkg::CNT_W-1:0] count_r;
    logic [lss_pkg::CNT_W-1:0] count_nxt;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // A drop of the run condition sampled with ce high restarts the full holdoff
    always_comb
    begin
        if (!run)
            count_nxt = '0;
        else if (count_r == LAST)
            count_nxt = count_r;
        else
            count_nxt = count_r + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_r <= '0;
        else if (ce)
            count_r <= count_nxt;
    end

    assign done = run && (count_r == LAST);
    assign count = count_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    timer_restart_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ce && !run |=> count_r == '0)
        else $error("holdoff counter not cleared when run dropped");

    timer_bound_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        count_r <= LAST)
        else $error("holdoff counter passed its limit");

    done_after_count_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(done) |-> $past(run) && $past(count_r) >= LAST - 1'b1)
        else $error("holdoff done came early");

endmodule

`default_nettype wire

// file: lss_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module lss_sequencer
#(
    parameter longint unsigned HOLDOFF_CYCLES = lss_pkg::HOLDOFF_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire lss_pkg::lss_in_t ctl_i,
    output lss_pkg::lss_out_t stat_o,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lss_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    logic [31:0] ctrl_r;
    logic therm_fault_r;
    logic [31:0] prdata_r;
    lss_pkg::lss_out_t out_r;
    lss_pkg::lss_out_t out_nxt;
    logic ready;
    logic run;
    logic done;
    logic driver_en;
    logic shutter_open;
    logic [lss_pkg::CNT_W-1:0] hold_count;
    logic sw_inhibit;
    logic sw_shut;
    logic apb_wr;
    logic apb_setup;
    logic [31:0] stat_word;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    function automatic logic addr_mapped(input logic [lss_pkg::ADDR_W-1:0] a);
        addr_mapped = (a == lss_pkg::OFF_CTRL) || (a == lss_pkg::OFF_STAT)
            || (a == lss_pkg::OFF_HOLD);
    endfunction

    // Zero wait states; a low clock enable stretches the access
    assign pready = ce;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign apb_wr = psel && penable && pwrite && ce;
    assign apb_setup = psel && !penable && !pwrite && ce;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= lss_pkg::CTRL_RST;
        else if (apb_wr && paddr == lss_pkg::OFF_CTRL)
            ctrl_r <= {30'h0, pwdata[1:0]};
    end

    assign sw_inhibit = ctrl_r[lss_pkg::CTRL_INH_BIT];
    assign sw_shut = ctrl_r[lss_pkg::CTRL_SHUT_BIT];

    always_comb
    begin
        stat_word = 32'h0000_0000;
        stat_word[lss_pkg::STAT_LOOP_BIT] = out_r.loop_ind_green;
        stat_word[lss_pkg::STAT_READY_BIT] = out_r.ready_indicator;
        stat_word[lss_pkg::STAT_DONE_BIT] = done;
        stat_word[lss_pkg::STAT_SHUT_BIT] = out_r.shutter_indicator;
        stat_word[lss_pkg::STAT_THERM_BIT] = therm_fault_r;
        stat_word[lss_pkg::STAT_EMISSION_INDICATOR_BIT] = out_r.emission_indicator;
        stat_word[lss_pkg::STAT_FAULT_BIT] = out_r.fault_closed;
        stat_word[lss_pkg::STAT_RF_BIT] = out_r.rf_board_pwr;
    end

    // Read data is captured in the setup cycle so it comes from a flop
    // Limitation: a setup cycle with the clock enable low skips the capture
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (apb_setup)
        begin
            unique case (paddr)
                lss_pkg::OFF_CTRL: prdata_r <= ctrl_r;
                lss_pkg::OFF_STAT: prdata_r <= stat_word;
                lss_pkg::OFF_HOLD: prdata_r <= hold_count;
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_r;

    // ------------------------------------------------------------
    // Thermal latch
    // ------------------------------------------------------------
    // Only a power cycle (reset) clears it; there is no software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            therm_fault_r <= 1'b0;
        else if (ce && ctl_i.over_temp)
            therm_fault_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // Enable chain
    // ------------------------------------------------------------
    // Loop is a level: no memory of an earlier open loop
    assign ready = ctl_i.safety_loop && !ctl_i.inhibit_req && !sw_inhibit;
    assign run = ready && !therm_fault_r;

    lss_holdoff
    #(
        .CYCLES(HOLDOFF_CYCLES)
    )
    u_holdoff
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .run(run),
        .done(done),
        .count(hold_count)
    );

    assign driver_en = run && done;
    assign shutter_open = ctl_i.shutter_req && ready && !sw_shut;

    always_comb
    begin
        out_nxt.rf_board_pwr = run;
        out_nxt.rf_driver_en = driver_en;
        out_nxt.tickle_en = driver_en && ctl_i.shutter_req;
        out_nxt.pulse_out = driver_en && shutter_open && ctl_i.pwm_cmd;
        out_nxt.ready_closed = ready;
        out_nxt.shutter_closed = ctl_i.shutter_req && ready;
        out_nxt.loop_open_closed = !ctl_i.safety_loop;
        out_nxt.fault_closed = therm_fault_r || ctl_i.over_temp || ctl_i.no_strike;
        out_nxt.lasing_closed = out_nxt.pulse_out;
        out_nxt.ready_indicator = ready;
        out_nxt.shutter_indicator = shutter_open;
        out_nxt.loop_ind_green = ctl_i.safety_loop;
        out_nxt.thermal_indicator = therm_fault_r || ctl_i.over_temp;
        out_nxt.emission_indicator = out_nxt.pulse_out;
    end

    // All status pins come from flops, one cycle after the inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_r <= '0;
        else if (ce)
            out_r <= out_nxt;
    end

    assign stat_o = out_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    rf_off_unready_a: assert property (
        ce && !ready |=> !stat_o.rf_board_pwr && !stat_o.rf_driver_en)
        else $error("RF power present while not ready");

    driver_holdoff_a: assert property (
        $rose(stat_o.rf_driver_en) |-> hold_count == lss_pkg::CNT_W'(HOLDOFF_CYCLES))
        else $error("RF driver enabled before holdoff elapsed");

    no_tickle_shut_a: assert property (
        ce && !ctl_i.shutter_req |=> !stat_o.tickle_en)
        else $error("tickle applied with shutter request inactive");

    pulse_gate_a: assert property (
        stat_o.pulse_out |-> $past(ctl_i.shutter_req) && $past(ctl_i.safety_loop)
            && stat_o.ready_indicator && stat_o.shutter_indicator)
        else $error("pulse passed without shutter, loop and ready");

    thermal_latch_a: assert property (
        therm_fault_r |=> therm_fault_r)
        else $error("thermal fault cleared without power cycle");

    ready_on_loop_a: assert property (
        ce && ctl_i.safety_loop && !ctl_i.inhibit_req && !sw_inhibit
            |=> stat_o.ready_indicator)
        else $error("ready indicator late after loop closed");

    inhibit_hold_a: assert property (
        (ce && ctl_i.inhibit_req) [*2] |=> !stat_o.rf_driver_en && hold_count == '0)
        else $error("RF driver not held off under inhibit");

    shutter_status_a: assert property (
        ce |=> stat_o.shutter_closed == ($past(ctl_i.shutter_req) && stat_o.ready_closed))
        else $error("shutter status output mismatch");

    loop_removed_a: assert property (
        ce && $fell(ctl_i.safety_loop) |=> !stat_o.ready_indicator
            && !stat_o.loop_ind_green && stat_o.loop_open_closed && !stat_o.lasing_closed)
        else $error("loop removal did not shut down");

    fault_out_a: assert property (
        ce && (ctl_i.over_temp || ctl_i.no_strike) |=> stat_o.fault_closed)
        else $error("fault output not closed on fault");

    apb_err_a: assert property (
        psel && penable && !addr_mapped(paddr) |-> pslverr)
        else $error("unmapped access not flagged");

    ctrl_write_a: assert property (
        apb_wr && paddr == lss_pkg::OFF_CTRL
        |=> ctrl_r[1:0] == $past(pwdata[1:0]))
        else $error("control write did not land");

    // ------------------------------------------------------------
    // Output checks
    // ------------------------------------------------------------
    // Reset leaves every pin open, so the loop-open check waits for a
    // sampled release before it expects the pin to follow the loop

    ready_out_a: assert property (
        ce
        |=> stat_o.ready_closed == stat_o.ready_indicator)
        else $error("ready output disagrees with ready indicator");

    shutter_gate_a: assert property (
        stat_o.pulse_out
        |-> stat_o.shutter_indicator && stat_o.rf_driver_en)
        else $error("pulse passed with shutter closed");

    shutter_ready_a: assert property (
        ce && !ready
        |=> !stat_o.shutter_indicator && !stat_o.shutter_closed)
        else $error("shutter opened while not ready");

    shutter_drop_a: assert property (
        ce && !ctl_i.shutter_req
        |=> !stat_o.shutter_indicator && !stat_o.pulse_out)
        else $error("shutter stayed open after request removed");

    power_green_a: assert property (
        stat_o.rf_board_pwr
        |-> stat_o.loop_ind_green && stat_o.ready_indicator)
        else $error("RF power without green loop and ready");

    boards_first_a: assert property (
        ce && $past(ce) && $rose(run)
        |=> stat_o.rf_board_pwr && !stat_o.rf_driver_en)
        else $error("boards not powered ahead of the driver");

    inhibit_release_a: assert property (
        ce && $past(ce) && $fell(ctl_i.inhibit_req) && run
        |=> stat_o.rf_board_pwr && !stat_o.rf_driver_en)
        else $error("driver enabled at once after inhibit release");

    loop_open_out_a: assert property (
        ce && presetn && !ctl_i.safety_loop
        |=> stat_o.loop_open_closed && !stat_o.loop_ind_green)
        else $error("loop-open output not closed with loop open");

    lasing_out_a: assert property (
        ce
        |=> stat_o.lasing_closed == stat_o.pulse_out)
        else $error("lasing-active output disagrees with emitted pulses");

    thermal_power_a: assert property (
        ce && therm_fault_r
        |=> !stat_o.rf_board_pwr && stat_o.thermal_indicator)
        else $error("power kept while thermal fault latched");

    emission_indicator_cov_c: cover property (ce && ctl_i.safety_loop ##1 stat_o.ready_indicator
        ##[1:200] stat_o.pulse_out);
    inhibit_cov_c: cover property ($fell(ctl_i.inhibit_req) ##[1:100] $rose(stat_o.rf_driver_en));
    thermal_cov_c: cover property ($rose(therm_fault_r));
    ctrl_wr_cov_c: cover property (apb_wr && paddr == lss_pkg::OFF_CTRL);
    shut_force_cov_c: cover property (ce && sw_shut && ctl_i.shutter_req && ready);

endmodule

`default_nettype wire

// file: lss_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module lss_ctrl_model
#(
    parameter int LAG = 1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire lss_pkg::lss_in_t want,
    output lss_pkg::lss_in_t ctl
);
    // ------------------------------------------------------------
    // Controller output card
    // ------------------------------------------------------------
    // Levels move only at a clock edge, LAG edges after the request,
    // to act like a controller with a slow scan cycle
    lss_pkg::lss_in_t pipe_r [0:LAG-1];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Loop held open through reset; the loop closes again LAG edges after
            // release if want still holds it closed, with no new request needed
            for (int i = 0; i < LAG; i++)
            begin
                pipe_r[i] <= '0;
            end
        end
        else
        begin
            pipe_r[0] <= want;
            for (int i = 1; i < LAG; i++)
            begin
                pipe_r[i] <= pipe_r[i-1];
            end
        end
    end

    assign ctl = pipe_r[LAG-1];

endmodule

`default_nettype wire

// file: lss_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none

module lss_sequencer_tb;
    localparam longint unsigned HOLD = 64'h0000_0000_0000_0014;
    localparam int LAG = 2;
    localparam int LIMIT = 3000;
    localparam logic [5:0] LOOP = 6'h20;
    localparam logic [5:0] SHUT = 6'h10;
    localparam logic [5:0] INH = 6'h08;
    localparam logic [5:0] HOT = 6'h04;
    localparam logic [5:0] NOST = 6'h02;
    localparam logic [5:0] PWM = 6'h01;

    logic pclk;
    logic presetn;
    logic ce;
    logic psel;
    logic penable;
    logic pwrite;
    logic [lss_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    lss_pkg::lss_in_t want;
    lss_pkg::lss_in_t ctl;
    lss_pkg::lss_out_t st;
    int error_cnt;
    int total_checks;
    int cycles;
    logic [31:0] rd;
    logic err;

    always #2 pclk = ~pclk;

    lss_ctrl_model #(.LAG(LAG)) lss_ctrl_model_inst (.pclk(pclk), .presetn(presetn),
        .want(want), .ctl(ctl));

    lss_sequencer #(.HOLDOFF_CYCLES(HOLD)) lss_sequencer_inst (.pclk(pclk),
        .presetn(presetn), .ce(ce), .ctl_i(ctl), .stat_o(st), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task results;
        begin
            $display("checks %0d mismatches %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        begin
            total_checks++;
            if (got !== exp)
            begin
                error_cnt++;
                $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
            end
        end
    endtask

    task wait_cyc(input int n);
        begin
            repeat (n) @(posedge pclk);
            #1;
        end
    endtask

    // Controller level change, then wait until it has reached the outputs
    task set_in(input lss_pkg::lss_in_t v);
        begin
            @(posedge pclk);
            want <= v;
            wait_cyc(LAG + 2);
        end
    endtask

    task wait_drv(input int lim);
        int n;
        begin
            n = 0;
            while (st.rf_driver_en !== 1'h1 && n < lim)
            begin
                wait_cyc(1);
                n++;
            end
            check(st.rf_driver_en, 32'h1, "driver late");
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            @(posedge pclk);
            psel <= 1'h1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'h1;
            @(posedge pclk);
            while (pready !== 1'h1 && n < 50)
            begin
                @(posedge pclk);
                n++;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
            check(n < 50, 32'h1, "no pready");
        end
    endtask

    task done_test(input string name);
        $display("test %s done", name);
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            error_cnt++;
            $display("BAD t=%0t timeout", $time);
            results();
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'h0;
        presetn = 1'h0;
        ce = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = 32'h0;
        want = '0;
        error_cnt = 0;
        total_checks = 0;
        cycles = 0;
        repeat (9) @(posedge pclk);
        #1;
        check(32'(st), 32'h0, "reset outputs");
        @(posedge pclk);
        presetn <= 1'h1;
        wait_cyc(1);
        check(32'(st), 32'h0000_0080, "idle outputs");
        done_test("reset");
        set_in(LOOP);
        check(st.ready_indicator, 32'h1, "ready on");
        check(st.rf_board_pwr, 32'h1, "board power");
        check(st.loop_ind_green, 32'h1, "green");
        check(st.loop_open_closed, 32'h0, "loop out");
        check(st.ready_closed, 32'h1, "ready out");
        wait_cyc(12);
        check(st.rf_driver_en, 32'h0, "driver early");
        wait_drv(20);
        check(st.tickle_en, 32'h0, "tickle without shutter");
        set_in(LOOP | SHUT | PWM);
        check(st.shutter_indicator, 32'h1, "shutter lamp");
        check(st.shutter_closed, 32'h1, "shutter out");
        check(st.tickle_en, 32'h1, "tickle");
        check(st.pulse_out, 32'h1, "pulse");
        check(st.lasing_closed, 32'h1, "lasing out");
        check(st.emission_indicator, 32'h1, "emission lamp");
        set_in(LOOP | PWM);
        check(st.shutter_indicator, 32'h0, "shutter lamp off");
        check(st.pulse_out, 32'h0, "pulse blocked");
        check(st.shutter_closed, 32'h0, "shutter out off");
        done_test("enable");
        apb(1'h0, lss_pkg::OFF_STAT, 32'h0);
        check(rd, 32'h0000_0087, "status");
        apb(1'h1, lss_pkg::OFF_STAT, 32'h0000_00FF);
        apb(1'h0, lss_pkg::OFF_STAT, 32'h0);
        check(rd, 32'h0000_0087, "status read only");
        apb(1'h1, lss_pkg::OFF_CTRL, 32'h0000_0001);
        wait_cyc(3);
        check(st.rf_driver_en, 32'h0, "soft inhibit");
        apb(1'h0, lss_pkg::OFF_CTRL, 32'h0);
        check(rd, 32'h0000_0001, "ctrl readback");
        apb(1'h1, lss_pkg::OFF_CTRL, 32'h0);
        wait_drv(30);
        apb(1'h0, lss_pkg::OFF_HOLD, 32'h0);
        check(rd, 32'(HOLD), "holdoff count");
        apb(1'h0, 12'h00C, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000, "unmapped");
        @(posedge pclk);
        ce <= 1'h0;
        wait_cyc(1);
        check(pready, 32'h0, "frozen");
        @(posedge pclk);
        ce <= 1'h1;
        done_test("registers");
        set_in(LOOP | INH);
        check(st.rf_driver_en, 32'h0, "inhibit driver");
        check(st.rf_board_pwr, 32'h0, "inhibit power");
        set_in(LOOP);
        wait_cyc(6);
        set_in(LOOP | INH);
        set_in(LOOP);
        wait_cyc(14);
        check(st.rf_driver_en, 32'h0, "holdoff restart");
        wait_drv(20);
        done_test("inhibit");
        set_in(SHUT | PWM);
        check(st.ready_indicator, 32'h0, "ready off");
        check(st.loop_ind_green, 32'h0, "red");
        check(st.loop_open_closed, 32'h1, "loop open out");
        check(st.shutter_indicator, 32'h0, "shutter no ready");
        check(st.pulse_out, 32'h0, "pulse no loop");
        check(st.rf_board_pwr, 32'h0, "power no loop");
        set_in(LOOP | SHUT | PWM);
        check(st.rf_driver_en, 32'h0, "emission_indicator not at once");
        wait_drv(30);
        check(st.pulse_out, 32'h1, "pulse resumes");
        apb(1'h1, lss_pkg::OFF_CTRL, 32'h0000_0002);
        wait_cyc(2);
        check(st.shutter_indicator, 32'h0, "shutter forced closed");
        check(st.pulse_out, 32'h0, "pulse forced off");
        check(st.shutter_closed, 32'h1, "status ignores force");
        apb(1'h1, lss_pkg::OFF_CTRL, 32'h0);
        done_test("loop");
        set_in(LOOP | NOST);
        check(st.fault_closed, 32'h1, "no strike fault");
        set_in(LOOP);
        check(st.fault_closed, 32'h0, "fault clear");
        set_in(LOOP | HOT);
        set_in(LOOP);
        check(st.thermal_indicator, 32'h1, "thermal latched");
        check(st.fault_closed, 32'h1, "thermal fault out");
        check(st.rf_board_pwr, 32'h0, "thermal power off");
        @(posedge pclk);
        presetn <= 1'h0;
        wait_cyc(3);
        @(posedge pclk);
        presetn <= 1'h1;
        wait_cyc(LAG + 3);
        check(st.thermal_indicator, 32'h0, "power cycle clears");
        check(st.ready_indicator, 32'h1, "ready after cycle");
        done_test("faults");
        results();
    end

endmodule

`default_nettype wire
